// File: hw/ist_slave.sv
/*
 * Two-wire bus slave engine with bus time-out: address match, byte
 * shifting through a shared data buffer, clock stretching until
 * software services the buffer, and a time-out that restores status.
 * Assumes open-drain pins resolved outside, a free-running sub clock
 * pin, and a register master that never waits.
 */
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module ist_slave
   import ist_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   input  wire logic [2:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe_out,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   input  wire logic       sub_clk_in,
   output logic            serial_irq_out
);

   // Synchronised pins: bit 0 SCL, bit 1 SDA, bit 2 sub clock
   logic [2:0] pin_lvl;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;

   ist_sync #(
      .WIDTH     (3)
   ) u_sync (
      .clk_in    (clk_in),
      .reset_in  (reset_in),
      .pin_in    ({sub_clk_in, sda_in, scl_in}),
      .level_out (pin_lvl),
      .rise_out  (pin_rise),
      .fall_out  (pin_fall)
   );

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   assign scl_s     = pin_lvl[0];
   assign sda_s     = pin_lvl[1];
   assign scl_rise  = pin_rise[0];
   assign scl_fall  = pin_fall[0];
   assign start_det = pin_fall[1] & scl_s;
   assign stop_det  = pin_rise[1] & scl_s;

   // Registers
   logic [7:0] data_ff;
   logic [7:0] own_ff;
   logic [7:0] mode_ff;
   logic [7:0] stat_ff;
   logic [7:0] toc_ff;
   logic [7:0] rdata_ff;

   // Engine state
   ist_state_t state_ff;
   logic [7:0] shreg_ff;
   logic [2:0] bitcnt_ff;
   logic       ack_tx_ff;      // Ack phase samples the master rather than drives
   logic       ack_val_ff;     // Level to drive during an ack phase
   logic       ack_fall_ff;    // First SCL fall of the ack phase seen
   logic       sda_oe_ff;
   logic       scl_hold_ff;
   logic       tmo_run_ff;
   logic       irq_ff;

   // Decoded strobes and engine events
   logic wr_data;
   logic rd_data;
   logic wr_stat;
   logic wr_toc;
   logic eng_en;
   logic addr_done;
   logic match;
   logic rx_done;
   logic tx_done;
   logic ack_sample;
   logic serviced;
   logic tmo_hit;

   assign wr_data = wr_in & (addr_in == OFS_DATA);
   assign rd_data = rd_in & (addr_in == OFS_DATA);
   assign wr_stat = wr_in & (addr_in == OFS_STAT);
   assign wr_toc  = wr_in & (addr_in == OFS_TOC);
   assign eng_en  = mode_ff[MODE_EN];

   assign addr_done  = (state_ff == IST_ADDR) & scl_rise & (bitcnt_ff == LAST_BIT);
   assign match      = addr_done & (shreg_ff[6:0] == own_ff[6:0]);
   assign rx_done    = (state_ff == IST_RX) & scl_rise & (bitcnt_ff == LAST_BIT);
   assign tx_done    = (state_ff == IST_TX) & scl_rise & (bitcnt_ff == LAST_BIT);
   assign ack_sample = (state_ff == IST_ACK) & ack_tx_ff & ack_fall_ff & scl_rise;
   // Buffer write releases a transmitter, a dummy read releases a receiver
   assign serviced   = stat_ff[STAT_HTX] ? wr_data : rd_data;

   // Time-out counter, running only while enabled and a matched frame lasts
   ist_timeout u_timeout (
      .clk_in        (clk_in),
      .reset_in      (reset_in),
      .run_in        (tmo_run_ff & toc_ff[TOC_EN]),
      .clear_in      (scl_fall),
      .sub_edge_in   (pin_rise[2]),
      .period_sel_in (toc_ff[TOC_SEL_W-1:0]),
      .expire_out    (tmo_hit)
   );

   // Time-out window opens on a match and closes on STOP or expiry
   always_ff @(posedge clk_in)
   begin
      if (reset_in || tmo_hit || stop_det || !eng_en)
         tmo_run_ff <= 1'b0;
      else if (match)
         tmo_run_ff <= 1'b1;
   end

   // Own address and mode registers survive a time-out untouched
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         own_ff  <= OWN_RST;
         mode_ff <= MODE_RST;
      end
      else if (wr_in)
      begin
         if (addr_in == OFS_OWN)
            own_ff <= wdata_in;
         if (addr_in == OFS_MODE)
            mode_ff <= wdata_in;
      end
   end

   // Shared data buffer: software loads it, received bytes overwrite it
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         data_ff <= DATA_RST;
      else if (rx_done)
         data_ff <= {shreg_ff[6:0], sda_s};
      else if (wr_data)
         data_ff <= wdata_in;
   end

   // Status/control register; hardware events win over software writes
   always_ff @(posedge clk_in)
   begin
      if (reset_in || tmo_hit || !eng_en)
         stat_ff <= STAT_RST;
      else
      begin
         if (wr_stat)
         begin
            stat_ff[STAT_HTX]  <= wdata_in[STAT_HTX];
            stat_ff[STAT_OUTGOING_ACK_BIT] <= wdata_in[STAT_OUTGOING_ACK_BIT];
            stat_ff[STAT_WAKE] <= wdata_in[STAT_WAKE];
         end
         if (start_det)
         begin
            stat_ff[STAT_BUSY]  <= 1'b1;
            stat_ff[STAT_MATCH] <= 1'b0;
         end
         else if (stop_det)
            stat_ff[STAT_BUSY] <= 1'b0;
         if (match)
         begin
            stat_ff[STAT_MATCH] <= 1'b1;
            stat_ff[STAT_SRW]   <= sda_s;
         end
         // Flag low while a data byte moves, high once eight bits are in
         if (scl_fall && (state_ff == IST_RX || state_ff == IST_TX)
             && bitcnt_ff == 3'h1)
            stat_ff[STAT_DONE] <= 1'b0;
         if (addr_done || rx_done || tx_done)
            stat_ff[STAT_DONE] <= 1'b1;
         if (ack_sample)
            stat_ff[STAT_INCOMING_ACK_FLAG] <= sda_s;
      end
   end

   // Time-out control; expiry clears enable and sets the sticky flag
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         toc_ff <= TOC_RST;
      else
      begin
         if (wr_toc)
            toc_ff <= wdata_in;
         if (tmo_hit)
         begin
            toc_ff[TOC_EN]   <= 1'b0;
            toc_ff[TOC_FLAG] <= 1'b1;
         end
         else if (wr_toc)
            toc_ff[TOC_FLAG] <= toc_ff[TOC_FLAG] & wdata_in[TOC_FLAG];
      end
   end

   // One interrupt pulse for match, byte completion or time-out
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         irq_ff <= 1'b0;
      else
         irq_ff <= match | rx_done | tx_done | tmo_hit;
   end

   // Read data stand in the cycle after the strobe; unmapped reads as zero
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         rdata_ff <= 8'h00;
      else if (rd_in)
      begin
         case (addr_in)
            OFS_DATA: rdata_ff <= data_ff;
            OFS_OWN:  rdata_ff <= own_ff;
            OFS_MODE: rdata_ff <= mode_ff;
            OFS_STAT: rdata_ff <= stat_ff;
            OFS_TOC:  rdata_ff <= toc_ff;
            default:  rdata_ff <= 8'h00;
         endcase
      end
      else
         rdata_ff <= 8'h00;
   end

   // Serial engine: bits are sampled on SCL rise and driven after SCL fall
   always_ff @(posedge clk_in)
   begin
      if (reset_in || tmo_hit || !eng_en)
      begin
         state_ff    <= IST_IDLE;
         shreg_ff    <= 8'h00;
         bitcnt_ff   <= 3'h0;
         ack_tx_ff   <= 1'b0;
         ack_val_ff  <= 1'b1;
         ack_fall_ff <= 1'b0;
         sda_oe_ff   <= 1'b0;
         scl_hold_ff <= 1'b0;
      end
      else if (start_det)
      begin
         // A repeated START aborts whatever was in flight
         state_ff    <= IST_ADDR;
         bitcnt_ff   <= 3'h0;
         sda_oe_ff   <= 1'b0;
         scl_hold_ff <= 1'b0;
      end
      else if (stop_det)
      begin
         state_ff    <= IST_IDLE;
         sda_oe_ff   <= 1'b0;
         scl_hold_ff <= 1'b0;
      end
      else
      begin
         case (state_ff)
            IST_IDLE:
               state_ff <= IST_IDLE;
            IST_ADDR:
               if (scl_rise)
               begin
                  shreg_ff  <= {shreg_ff[6:0], sda_s};
                  bitcnt_ff <= bitcnt_ff + 3'h1;
                  if (bitcnt_ff == LAST_BIT)
                  begin
                     ack_tx_ff   <= 1'b0;
                     ack_val_ff  <= 1'b0;
                     ack_fall_ff <= 1'b0;
                     state_ff    <= match ? IST_ACK : IST_PARK;
                  end
               end
            IST_ACK:
               if (scl_fall)
               begin
                  if (!ack_fall_ff)
                  begin
                     // Ninth bit: drive our ack or leave SDA to the master
                     ack_fall_ff <= 1'b1;
                     sda_oe_ff   <= ~ack_tx_ff & ~ack_val_ff;
                  end
                  else
                  begin
                     sda_oe_ff <= 1'b0;
                     if (ack_tx_ff && stat_ff[STAT_INCOMING_ACK_FLAG])
                        state_ff <= IST_PARK;
                     else
                     begin
                        scl_hold_ff <= 1'b1;
                        state_ff    <= IST_SERVICE;
                     end
                  end
               end
            IST_SERVICE:
               if (serviced)
               begin
                  scl_hold_ff <= 1'b0;
                  bitcnt_ff   <= 3'h0;
                  if (stat_ff[STAT_HTX])
                  begin
                     // MSB is put on SDA in the same cycle that the SCL hold is released
                     shreg_ff  <= wdata_in;
                     sda_oe_ff <= ~wdata_in[7];
                     state_ff  <= IST_TX;
                  end
                  else
                     state_ff <= IST_RX;
               end
            IST_RX:
               if (scl_rise)
               begin
                  shreg_ff  <= {shreg_ff[6:0], sda_s};
                  bitcnt_ff <= bitcnt_ff + 3'h1;
                  if (bitcnt_ff == LAST_BIT)
                  begin
                     ack_tx_ff   <= 1'b0;
                     ack_val_ff  <= stat_ff[STAT_OUTGOING_ACK_BIT];
                     ack_fall_ff <= 1'b0;
                     state_ff    <= IST_ACK;
                  end
               end
            IST_TX:
               if (scl_rise)
               begin
                  bitcnt_ff <= bitcnt_ff + 3'h1;
                  if (bitcnt_ff == LAST_BIT)
                  begin
                     ack_tx_ff   <= 1'b1;
                     ack_fall_ff <= 1'b0;
                     state_ff    <= IST_ACK;
                  end
               end
               else if (scl_fall && bitcnt_ff != 3'h0)
               begin
                  // Next bit goes out after each fall, MSB first
                  shreg_ff  <= {shreg_ff[6:0], 1'b0};
                  sda_oe_ff <= ~shreg_ff[6];
               end
            IST_PARK:
               sda_oe_ff <= 1'b0;
            default:
               state_ff <= IST_IDLE;
         endcase
      end
   end

   // Open-drain outputs only ever pull low
   assign scl_out        = 1'b0;
   assign sda_out        = 1'b0;
   assign scl_oe_out     = scl_hold_ff;
   assign sda_oe_out     = sda_oe_ff;
   assign rdata_out      = rdata_ff;
   assign serial_irq_out = irq_ff;

endmodule // ist_slave

// File: hw/ist_pkg.sv
/*
 * Shared constants for the two-wire slave engine with bus time-out:
 * register offsets, field positions, reset values and engine states.
 * Assumes an 8-bit register port with a 3-bit word address.
 */
package ist_pkg;

   // Register offsets on the plain register port
   localparam logic [2:0] OFS_DATA = 3'h0;     // serial_data_buffer
   localparam logic [2:0] OFS_OWN  = 3'h1;     // own_address_register
   localparam logic [2:0] OFS_MODE = 3'h2;     // serial_mode_register
   localparam logic [2:0] OFS_STAT = 3'h3;     // bus_status_control_register
   localparam logic [2:0] OFS_TOC  = 3'h4;     // bus_timeout_control

   // Status/control register fields
   localparam int STAT_DONE  = 7;              // transfer_complete_flag
   localparam int STAT_MATCH = 6;              // address_match_flag
   localparam int STAT_BUSY  = 5;              // bus_busy_flag
   localparam int STAT_HTX   = 4;              // transmit_role_select
   localparam int STAT_OUTGOING_ACK_BIT  = 3;              // outgoing_ack_bit
   localparam int STAT_SRW   = 2;              // master_direction_flag
   localparam int STAT_WAKE  = 1;              // wake-up control, stored only
   localparam int STAT_INCOMING_ACK_FLAG  = 0;              // incoming_ack_flag

   // Mode register: bit 1 switches the engine on
   localparam int MODE_EN = 1;

   // Time-out control fields
   localparam int TOC_EN   = 7;                // timeout_enable
   localparam int TOC_FLAG = 6;                // timeout_flag
   localparam int TOC_SEL_W = 6;               // timeout_period_select width

   // Reset values
   localparam logic [7:0] STAT_RST = 8'h81;
   localparam logic [7:0] MODE_RST = 8'he0;
   localparam logic [7:0] TOC_RST  = 8'h00;
   localparam logic [7:0] OWN_RST  = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;

   // Serial framing and time-out tick
   localparam logic [2:0] LAST_BIT   = 3'h7;   // index of the 8th bit of a byte
   localparam int         SUB_DIV    = 32;     // sub clock edges per time-out tick
   localparam logic [4:0] PRESC_LAST = 5'(SUB_DIV - 1);

   // Engine states
   typedef enum logic [2:0] {
      IST_IDLE    = 3'b000,
      IST_ADDR    = 3'b001,
      IST_ACK     = 3'b010,
      IST_SERVICE = 3'b011,
      IST_RX      = 3'b100,
      IST_TX      = 3'b101,
      IST_PARK    = 3'b110
   } ist_state_t;

endpackage

// File: hw/ist_sync.sv
/*
 * Two-flop synchronisers with edge detection for pin inputs.
 * Assumes every input is asynchronous to clk_in; the edge pulses
 * come from the second flop and a third history flop only.
 */
`timescale 1ns/10ps
module ist_sync
   import ist_pkg::*;
#(
   parameter int WIDTH = 3
)(
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level_out,
   output logic      [WIDTH-1:0] rise_out,
   output logic      [WIDTH-1:0] fall_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         logic meta_ff;
         logic stable_ff;
         logic hist_ff;

         // Idle bus lines are high, so reset to one to avoid false edges
         always_ff @(posedge clk_in)
         begin
            if (reset_in)
            begin
               meta_ff   <= 1'b1;
               stable_ff <= 1'b1;
               hist_ff   <= 1'b1;
            end
            else
            begin
               meta_ff   <= pin_in[i];
               stable_ff <= meta_ff;
               hist_ff   <= stable_ff;
            end
         end

         assign level_out[i] = stable_ff;
         assign rise_out[i]  = stable_ff & ~hist_ff;
         assign fall_out[i]  = ~stable_ff & hist_ff;
      end
   endgenerate

endmodule // ist_sync

// File: hw/ist_timeout.sv
/*
 * Bus time-out counter: divides sub clock edges by 32 into ticks and
 * fires after (select + 1) ticks unless cleared first.
 * Assumes sub_edge_in is a synchronised one-cycle pulse.
 */
`timescale 1ns/10ps
module ist_timeout
   import ist_pkg::*;
(
   input  wire logic                 clk_in,
   input  wire logic                 reset_in,
   input  wire logic                 run_in,
   input  wire logic                 clear_in,
   input  wire logic                 sub_edge_in,
   input  wire logic [TOC_SEL_W-1:0] period_sel_in,
   output logic                      expire_out
);

   logic [4:0]           presc_ff;
   logic [TOC_SEL_W-1:0] ticks_ff;
   logic                 tick;

   assign tick       = run_in & sub_edge_in & (presc_ff == PRESC_LAST);
   assign expire_out = tick & (ticks_ff == period_sel_in);

   // Prescaler restarts on every clear, so each period is whole ticks
   always_ff @(posedge clk_in)
   begin
      if (reset_in || clear_in || !run_in)
         presc_ff <= 5'h00;
      else if (sub_edge_in)
         presc_ff <= presc_ff + 5'h01;
   end

   // Tick counter clears after expiry because run drops with the enable
   always_ff @(posedge clk_in)
   begin
      if (reset_in || clear_in || !run_in)
         ticks_ff <= '0;
      else if (tick)
         ticks_ff <= ticks_ff + 6'h01;
   end

endmodule // ist_timeout

// File: sim/ist_slave_asserts.sv
/* Port-level assertions for the two-wire slave.
   Bound into every ist_slave; sees only its ports. */
`timescale 1ns/10ps
module ist_slave_asserts
   import ist_pkg::*;
(
   input wire logic       clk_in,
   input wire logic       reset_in,
   input wire logic [2:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic       wr_in,
   input wire logic       rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic       scl_in,
   input wire logic       scl_out,
   input wire logic       scl_oe_out,
   input wire logic       sda_out,
   input wire logic       sda_oe_out,
   input wire logic       serial_irq_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   logic [7:0] own_ff;
   logic [7:0] mode_ff;
   logic [5:0] sel_ff;
   logic       htx_ff;
   // Shadows of software writes; a time-out must not disturb own, mode or period select (it does reset HTX)
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         own_ff <= OWN_RST;
         mode_ff <= MODE_RST;
         sel_ff <= 6'h00;
         htx_ff <= 1'b0;
      end
      else if (wr_in)
      begin
         if (addr_in == OFS_OWN) own_ff <= wdata_in;
         if (addr_in == OFS_MODE) mode_ff <= wdata_in;
         if (addr_in == OFS_TOC) sel_ff <= wdata_in[5:0];
         if (addr_in == OFS_STAT) htx_ff <= wdata_in[STAT_HTX];
      end
   end
   a_irq_pulse: assert property (serial_irq_out |=> !serial_irq_out)
      else $error("interrupt longer than one cycle");
   a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside its cycle");
   a_own_keep: assert property (rd_in && addr_in == OFS_OWN |=> rdata_out == own_ff)
      else $error("own address lost");
   a_mode_keep: assert property (rd_in && addr_in == OFS_MODE |=> rdata_out == mode_ff)
      else $error("mode register lost");
   a_sel_keep: assert property (rd_in && addr_in == OFS_TOC |=> rdata_out[5:0] == sel_ff)
      else $error("period select lost");
   a_stretch_low: assert property ($rose(scl_oe_out) |-> !scl_in)
      else $error("stretch began with clock high");
   a_sda_moves_low: assert property ($changed(sda_oe_out) |-> !scl_in)
      else $error("data line moved while clock high");
   a_rx_release: assert property (rd_in && addr_in == OFS_DATA && scl_oe_out && !htx_ff
      |-> ##[1:2] !scl_oe_out)
      else $error("dummy read kept clock low");
   a_tx_release: assert property (wr_in && addr_in == OFS_DATA && scl_oe_out && htx_ff
      |-> ##[1:2] !scl_oe_out)
      else $error("buffer write kept clock low");
   a_open_drain: assert property (sda_out == 1'b0 && scl_out == 1'b0)
      else $error("pin data not low");
endmodule // ist_slave_asserts

bind ist_slave ist_slave_asserts i_ist_slave_asserts (.clk_in(clk_in), .reset_in(reset_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .serial_irq_out(serial_irq_out));

// File: sim/ist_bus_master.sv
/* Behavioural bus master for the two-wire link.
   Assumes pulled-up wires resolved by the bench; 1 on a drive = release. */
`timescale 1ns/10ps
module ist_bus_master
#(
   parameter int HALF = 20
)(
   input  wire logic clk_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      scl_drv_out,
   output logic      sda_drv_out
);
   int stall_cnt = 0;
   initial
   begin
      scl_drv_out = 1'b1;
      sda_drv_out = 1'b1;
   end
   task automatic half();
      repeat (HALF) @(posedge clk_in);
   endtask
   // Release clock and wait out a stretch; a bound keeps a stuck slave visible
   task automatic scl_up();
      int n;
      n = 0;
      scl_drv_out <= 1'b1;
      @(posedge clk_in);
      while (!scl_in && n < 5000)
      begin
         @(posedge clk_in);
         n++;
      end
      if (!scl_in) stall_cnt++;
   endtask
   // Data only moves with clock low, so no false start or stop
   task automatic clk_bit(input logic d, output logic s);
      sda_drv_out <= d;
      half();
      scl_up();
      s = sda_in;
      half();
      scl_drv_out <= 1'b0;
      half();
   endtask
   task automatic start();
      sda_drv_out <= 1'b1;
      half();
      scl_up();
      half();
      sda_drv_out <= 1'b0;
      half();
      scl_drv_out <= 1'b0;
      half();
   endtask
   task automatic stop();
      sda_drv_out <= 1'b0;
      half();
      scl_up();
      half();
      sda_drv_out <= 1'b1;
      half();
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
      clk_bit(1'b1, ack);
   endtask
   task automatic read_byte(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
      clk_bit(nack, s);
   endtask
endmodule // ist_bus_master

// File: sim/tb_ist_slave.sv
/* Self-checking bench for ist_slave: register tasks, a bus master model,
   queued read expectations compared by a monitor. Needs ist_pkg. */
`timescale 1ns/10ps
module tb_ist_slave
   import ist_pkg::*;
;
   logic       clk_in = 1'b0;
   logic       reset_in = 1'b1;
   logic [2:0] addr_in = 3'h0;
   logic [7:0] wdata_in = 8'h00;
   logic       wr_in = 1'b0;
   logic       rd_in = 1'b0;
   logic       sub_clk_in = 1'b0;
   logic       rd_d = 1'b0;
   logic [7:0] irq_cnt = 8'h00;
   logic [7:0] rdata_out, b, d1, d2, t1, t2;
   logic       scl_out, scl_oe_out, sda_out, sda_oe_out, serial_irq_out, scl_m, sda_m, ack;
   logic [6:0] own;
   logic [7:0] exp_q[$];
   logic [7:0] msk_q[$];
   int         mismatches = 0, total_checks = 0, seed = 77639, n;
   wire        scl = scl_m & ~scl_oe_out; // Pull-ups on both wires
   wire        sda = sda_m & ~sda_oe_out;
   initial forever #50 clk_in = ~clk_in;
   initial forever #400 sub_clk_in = ~sub_clk_in; // 8 clocks, well below clk/4
   ist_slave i_ist_slave (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .scl_in(scl), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_out(sda_oe_out), .sub_clk_in(sub_clk_in),
      .serial_irq_out(serial_irq_out));
   ist_bus_master i_ist_bus_master (.clk_in(clk_in), .scl_in(scl), .sda_in(sda),
      .scl_drv_out(scl_m), .sda_drv_out(sda_m));
   task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
      total_checks++;
      if (seen !== expv)
      begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   // Expected value is noted first; the monitor pairs it with the answer
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   always @(posedge clk_in)
   begin
      rd_d <= rd_in;
      if (rd_d === 1'b1) chk(rdata_out & msk_q.pop_front(), exp_q.pop_front());
      if (serial_irq_out === 1'b1) irq_cnt <= irq_cnt + 8'h01;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (100000) @(posedge clk_in);
      mismatches++;
      final_report();
   end
   initial
   begin
      own = 7'($random(seed));
      d1 = 8'($random(seed));
      d2 = 8'($random(seed));
      t1 = 8'($random(seed));
      t2 = 8'($random(seed));
      repeat (10) @(posedge clk_in);
      reset_in <= 1'b0;
      rd(OFS_DATA, DATA_RST, 8'hff);
      rd(OFS_OWN, OWN_RST, 8'hff);
      rd(OFS_MODE, MODE_RST, 8'hff);
      rd(OFS_STAT, STAT_RST, 8'hff);
      rd(OFS_TOC, TOC_RST, 8'hff);
      rd(3'h5, 8'h00, 8'hff);
      wr(OFS_OWN, {1'b0, own});
      wr(OFS_MODE, 8'h02);
      wr(OFS_TOC, 8'h81);
      // Master writes two bytes; software refuses the second
      i_ist_bus_master.start();
      i_ist_bus_master.send_byte({own, 1'b0}, ack);
      chk({7'h00, ack}, 8'h00);
      rd(OFS_STAT, 8'he0, 8'hfe);
      chk({7'h00, scl_oe_out}, 8'h01);
      rd(OFS_DATA, 8'h00, 8'h00);
      i_ist_bus_master.send_byte(d1, ack);
      chk({7'h00, ack}, 8'h00);
      rd(OFS_DATA, d1, 8'hff);
      wr(OFS_STAT, 8'h08);
      i_ist_bus_master.send_byte(d2, ack);
      chk({7'h00, ack}, 8'h01);
      rd(OFS_DATA, d2, 8'hff);
      chk(irq_cnt, 8'h03);
      i_ist_bus_master.stop();
      // Quiet bus after STOP must not time out
      repeat (600) @(posedge clk_in);
      rd(OFS_STAT, 8'h00, 8'h20);
      // Master reads two bytes and refuses the last
      i_ist_bus_master.start();
      i_ist_bus_master.send_byte({own, 1'b1}, ack);
      rd(OFS_STAT, 8'h44, 8'h44);
      wr(OFS_STAT, 8'h10);
      wr(OFS_DATA, t1);
      i_ist_bus_master.read_byte(1'b0, b);
      chk(b, t1);
      wr(OFS_DATA, t2);
      i_ist_bus_master.read_byte(1'b1, b);
      chk(b, t2);
      rd(OFS_STAT, 8'h01, 8'h01);
      chk({7'h00, sda_oe_out}, 8'h00);
      i_ist_bus_master.stop();
      // Another address is ignored
      i_ist_bus_master.start();
      i_ist_bus_master.send_byte({own ^ 7'h01, 1'b0}, ack);
      chk({7'h00, ack}, 8'h01);
      i_ist_bus_master.stop();
      chk(irq_cnt, 8'h06);
      // Unserviced stretch runs into a two-tick time-out
      wr(OFS_TOC, 8'h81);
      i_ist_bus_master.start();
      i_ist_bus_master.send_byte({own, 1'b0}, ack);
      n = 0;
      while (serial_irq_out !== 1'b1 && n < 2000)
      begin
         @(negedge clk_in);
         n++;
      end
      chk({7'h00, n > 470 && n < 512}, 8'h01);
      repeat (600) @(negedge clk_in);
      chk(irq_cnt, 8'h08);
      chk({7'h00, scl_oe_out}, 8'h00);
      rd(OFS_TOC, 8'h41, 8'hff);
      rd(OFS_STAT, STAT_RST, 8'hff);
      rd(OFS_OWN, {1'b0, own}, 8'hff);
      rd(OFS_MODE, 8'h02, 8'hff);
      wr(OFS_TOC, 8'h01);
      rd(OFS_TOC, 8'h01, 8'hff);
      i_ist_bus_master.stop();
      rd(OFS_STAT, 8'h00, 8'h20);
      chk(8'(i_ist_bus_master.stall_cnt), 8'h00);
      repeat (4) @(posedge clk_in);
      final_report();
   end
endmodule // tb_ist_slave
